// >>> src/lcf_pkg.sv
package lcf_pkg;
    // Seven-bit slave address with bit 0 taken from the select pin
    localparam logic [6:0] SLAVE_ADDR_BASE = 7'h38;
    localparam logic [5:0] PTR_LAST = 6'h27;
    localparam logic [6:0] RAM_WORDS = 7'h28;
    // Drive mode codes on drive_mode_hi/drive_mode_lo
    localparam logic [1:0] MODE_QUAD = 2'h0;
    localparam logic [1:0] MODE_STATIC = 2'h1;
    localparam logic [1:0] MODE_DUPLEX = 2'h2;
    localparam logic [1:0] MODE_TRIPLEX = 2'h3;
    // Pointer steps per stored byte
    localparam logic [6:0] STEP_STATIC = 7'h08;
    localparam logic [6:0] STEP_DUPLEX = 7'h04;
    localparam logic [6:0] STEP_TRIPLEX = 7'h03;
    localparam logic [6:0] STEP_QUAD = 7'h02;
    // Blink divide ratios in device clock cycles
    localparam int BLINK_DIV_1 = 768;
    localparam int BLINK_DIV_2 = 1536;
    localparam int BLINK_DIV_3 = 3072;
    // Reset values
    localparam logic [1:0] RST_MODE = 2'h0;
    localparam logic [5:0] RST_PTR = 6'h00;
    localparam logic [2:0] RST_SUB = 3'h0;
    localparam logic [1:0] RST_BLINK = 2'h0;
    typedef enum logic [2:0] {
        LCF_IDLE,
        LCF_ADDR,
        LCF_CMD,
        LCF_DATA,
        LCF_IGNORE
    } lcf_phase_t;
endpackage : lcf_pkg

// >>> src/lcf_sync.sv
`timescale 1ns/10ps
module lcf_sync #(
    parameter int WIDTH = 1
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] meta_d;
    logic [WIDTH-1:0] sync_q;
    logic [WIDTH-1:0] sync_d;

    always_comb begin
        meta_d = async_in;
        sync_d = meta_q;
    end

    // Resets high so an idle bus shows no false start
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= '1;
            sync_q <= '1;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign sync_out = sync_q;
endmodule : lcf_sync

// >>> src/lcf_front.sv
`timescale 1ns/10ps
module lcf_front #(
    parameter int BLINK_DIV1 = lcf_pkg::BLINK_DIV_1,
    parameter int BLINK_DIV2 = lcf_pkg::BLINK_DIV_2,
    parameter int BLINK_DIV3 = lcf_pkg::BLINK_DIV_3
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic hw_subaddr_bit0,
    input wire logic hw_subaddr_bit1,
    input wire logic hw_subaddr_bit2,
    input wire logic slave_addr_lsb_pin,
    output logic ram_wr_en,
    output logic [5:0] ram_wr_ptr,
    output logic [7:0] ram_wr_byte,
    output logic ram_wr_bank,
    output logic display_enable,
    output logic bias_sel,
    output logic drive_mode_hi,
    output logic drive_mode_lo,
    output logic [5:0] data_ptr,
    output logic [2:0] subaddr_cnt,
    output logic in_bank,
    output logic out_bank,
    output logic blink_alt,
    output logic blink_rate_hi,
    output logic blink_rate_lo,
    output logic display_on,
    output logic out_bank_eff
);
    logic scl_s;
    logic sda_s;
    logic [2:0] hw_sub;
    logic sa_s;
    logic scl_p_q;
    logic sda_p_q;
    logic scl_rise;
    logic scl_fall;
    logic start_ev;
    logic stop_ev;

    // Pins are not on ref_clk, so every one is synchronised
    lcf_sync #(.WIDTH(2)) u_bus_sync (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .async_in({scl_in, sda_in}),
        .sync_out({scl_s, sda_s})
    );
    lcf_sync #(.WIDTH(4)) u_pin_sync (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .async_in({slave_addr_lsb_pin, hw_subaddr_bit2,
                   hw_subaddr_bit1, hw_subaddr_bit0}),
        .sync_out({sa_s, hw_sub})
    );

    lcf_pkg::lcf_phase_t phase_q, phase_d;
    logic [3:0] bit_q, bit_d;
    logic [7:0] shift_q, shift_d;
    logic [7:0] shift_nx;
    logic in_ack_q, in_ack_d;
    logic ack_q, ack_d;
    logic pend_q, pend_d;
    logic en_q, en_d;
    logic bias_q, bias_d;
    logic [1:0] mode_q, mode_d;
    logic [5:0] ptr_q, ptr_d;
    logic [2:0] sub_q, sub_d;
    logic ibank_q, ibank_d;
    logic obank_q, obank_d;
    logic alt_q, alt_d;
    logic [1:0] rate_q, rate_d;
    logic wr_q, wr_d;
    logic [5:0] wr_ptr_q, wr_ptr_d;
    logic [7:0] wr_byte_q, wr_byte_d;
    logic wr_bank_q, wr_bank_d;
    logic [6:0] step;
    logic [6:0] ptr_sum;
    logic sub_match;
    logic byte_done;

    assign scl_rise = scl_s & ~scl_p_q;
    assign scl_fall = ~scl_s & scl_p_q;
    assign start_ev = scl_s & scl_p_q & sda_p_q & ~sda_s;
    assign stop_ev = scl_s & scl_p_q & ~sda_p_q & sda_s;
    assign shift_nx = {shift_q[6:0], sda_s};
    assign sub_match = (sub_q == hw_sub);
    assign byte_done = scl_rise & ~in_ack_q & (bit_q == 4'h7)
        & ((phase_q == lcf_pkg::LCF_ADDR) | (phase_q == lcf_pkg::LCF_CMD)
           | (phase_q == lcf_pkg::LCF_DATA)) & ~start_ev & ~stop_ev;

    always_comb begin
        unique case (mode_q)
            lcf_pkg::MODE_STATIC: step = lcf_pkg::STEP_STATIC;
            lcf_pkg::MODE_DUPLEX: step = lcf_pkg::STEP_DUPLEX;
            lcf_pkg::MODE_TRIPLEX: step = lcf_pkg::STEP_TRIPLEX;
            lcf_pkg::MODE_QUAD: step = lcf_pkg::STEP_QUAD;
        endcase
    end
    assign ptr_sum = {1'b0, ptr_q} + step;

    always_comb begin
        phase_d = phase_q;
        bit_d = bit_q;
        shift_d = shift_q;
        in_ack_d = in_ack_q;
        ack_d = ack_q;
        pend_d = pend_q;
        en_d = en_q;
        bias_d = bias_q;
        mode_d = mode_q;
        ptr_d = ptr_q;
        sub_d = sub_q;
        ibank_d = ibank_q;
        obank_d = obank_q;
        alt_d = alt_q;
        rate_d = rate_q;
        wr_d = 1'b0;
        wr_ptr_d = wr_ptr_q;
        wr_byte_d = wr_byte_q;
        wr_bank_d = wr_bank_q;
        if (start_ev) begin
            phase_d = lcf_pkg::LCF_ADDR;
            bit_d = 4'h0;
            in_ack_d = 1'b0;
            ack_d = 1'b0;
        end else if (stop_ev) begin
            phase_d = lcf_pkg::LCF_IDLE;
            bit_d = 4'h0;
            in_ack_d = 1'b0;
            ack_d = 1'b0;
        end else if (phase_q != lcf_pkg::LCF_IDLE
                     && phase_q != lcf_pkg::LCF_IGNORE) begin
            if (scl_rise && !in_ack_q && bit_q < 4'h8) begin
                shift_d = shift_nx;
                bit_d = bit_q + 4'h1;
            end
            if (byte_done) begin
                unique case (phase_q)
                    lcf_pkg::LCF_ADDR: begin
                        pend_d = (shift_nx[7:1]
                            == {lcf_pkg::SLAVE_ADDR_BASE[6:1], sa_s})
                            && !shift_nx[0];
                    end
                    lcf_pkg::LCF_CMD: pend_d = 1'b1;
                    default: begin
                        pend_d = sub_match;
                        wr_d = sub_match;
                        wr_ptr_d = ptr_q;
                        wr_byte_d = shift_nx;
                        wr_bank_d = ibank_q;
                        if (ptr_sum > {1'b0, lcf_pkg::PTR_LAST}) begin
                            ptr_d = 6'(ptr_sum - lcf_pkg::RAM_WORDS);
                            sub_d = sub_q + 3'h1;
                        end else begin
                            ptr_d = ptr_sum[5:0];
                        end
                    end
                endcase
            end
            if (scl_fall && bit_q == 4'h8 && !in_ack_q) begin
                // pull low for the ninth pulse if the byte was accepted (pend_q)
                in_ack_d = 1'b1;
                ack_d = pend_q;
            end else if (scl_fall && in_ack_q) begin
                in_ack_d = 1'b0;
                ack_d = 1'b0;
                bit_d = 4'h0;
                if (phase_q == lcf_pkg::LCF_ADDR) begin
                    phase_d = pend_q ? lcf_pkg::LCF_CMD
                                     : lcf_pkg::LCF_IGNORE;
                end else if (phase_q == lcf_pkg::LCF_CMD) begin
                    if (!shift_q[7]) begin
                        phase_d = lcf_pkg::LCF_DATA;
                    end
                    if (!shift_q[6]) begin
                        ptr_d = shift_q[5:0];
                    end else if (!shift_q[5]) begin
                        // bit 4 is not looked at
                        en_d = shift_q[3];
                        bias_d = shift_q[2];
                        mode_d = shift_q[1:0];
                    end else begin
                        unique case (shift_q[4:3])
                            2'h0: sub_d = shift_q[2:0];
                            2'h3: begin
                                ibank_d = shift_q[1];
                                obank_d = shift_q[0];
                            end
                            2'h2: begin
                                alt_d = shift_q[2];
                                rate_d = shift_q[1:0];
                            end
                            // Undefined code is a no-op
                            2'h1: begin
                            end
                        endcase
                    end
                end
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
            phase_q <= lcf_pkg::LCF_IDLE;
            bit_q <= 4'h0;
            shift_q <= 8'h00;
            in_ack_q <= 1'b0;
            ack_q <= 1'b0;
            pend_q <= 1'b0;
            en_q <= 1'b0;
            bias_q <= 1'b0;
            mode_q <= lcf_pkg::RST_MODE;
            ptr_q <= lcf_pkg::RST_PTR;
            sub_q <= lcf_pkg::RST_SUB;
            ibank_q <= 1'b0;
            obank_q <= 1'b0;
            alt_q <= 1'b0;
            rate_q <= lcf_pkg::RST_BLINK;
            wr_q <= 1'b0;
            wr_ptr_q <= 6'h00;
            wr_byte_q <= 8'h00;
            wr_bank_q <= 1'b0;
        end else begin
            scl_p_q <= scl_s;
            sda_p_q <= sda_s;
            phase_q <= phase_d;
            bit_q <= bit_d;
            shift_q <= shift_d;
            in_ack_q <= in_ack_d;
            ack_q <= ack_d;
            pend_q <= pend_d;
            en_q <= en_d;
            bias_q <= bias_d;
            mode_q <= mode_d;
            ptr_q <= ptr_d;
            sub_q <= sub_d;
            ibank_q <= ibank_d;
            obank_q <= obank_d;
            alt_q <= alt_d;
            rate_q <= rate_d;
            wr_q <= wr_d;
            wr_ptr_q <= wr_ptr_d;
            wr_byte_q <= wr_byte_d;
            wr_bank_q <= wr_bank_d;
        end
    end

    // Blinker: half period counted, phase toggles twice per period
    logic [11:0] bcnt_q, bcnt_d;
    logic bph_q, bph_d;
    logic don_q, don_d;
    logic obe_q, obe_d;
    logic [11:0] bhalf;
    logic alt_ok;

    always_comb begin
        unique case (rate_q)
            2'h1: bhalf = 12'(BLINK_DIV1 / 2);
            2'h2: bhalf = 12'(BLINK_DIV2 / 2);
            2'h3: bhalf = 12'(BLINK_DIV3 / 2);
            2'h0: bhalf = 12'h001;
        endcase
    end
    // Only static and duplex own a spare bank to swap in
    assign alt_ok = (mode_q == lcf_pkg::MODE_STATIC)
                  | (mode_q == lcf_pkg::MODE_DUPLEX);

    always_comb begin
        bcnt_d = bcnt_q;
        bph_d = bph_q;
        if (rate_q == 2'h0) begin
            bcnt_d = 12'h000;
            bph_d = 1'b0;
        end else if (bcnt_q >= bhalf - 12'h001) begin
            bcnt_d = 12'h000;
            bph_d = ~bph_q;
        end else begin
            bcnt_d = bcnt_q + 12'h001;
        end
        obe_d = obank_q ^ (alt_q & alt_ok & bph_q);
        don_d = en_q & ~(~alt_q & bph_q);
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            bcnt_q <= 12'h000;
            bph_q <= 1'b0;
            don_q <= 1'b0;
            obe_q <= 1'b0;
        end else begin
            bcnt_q <= bcnt_d;
            bph_q <= bph_d;
            don_q <= don_d;
            obe_q <= obe_d;
        end
    end

    // Open drain: only ever drives low
    assign sda_out = 1'b0;
    assign sda_oe = ack_q;
    assign ram_wr_en = wr_q;
    assign ram_wr_ptr = wr_ptr_q;
    assign ram_wr_byte = wr_byte_q;
    assign ram_wr_bank = wr_bank_q;
    assign display_enable = en_q;
    assign bias_sel = bias_q;
    assign drive_mode_hi = mode_q[1];
    assign drive_mode_lo = mode_q[0];
    assign data_ptr = ptr_q;
    assign subaddr_cnt = sub_q;
    assign in_bank = ibank_q;
    assign out_bank = obank_q;
    assign blink_alt = alt_q;
    assign blink_rate_hi = rate_q[1];
    assign blink_rate_lo = rate_q[0];
    assign display_on = don_q;
    assign out_bank_eff = obe_q;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    sequence s_data_byte;
        byte_done && phase_q == lcf_pkg::LCF_DATA;
    endsequence
    sequence s_cmd_end;
        scl_fall && in_ack_q && phase_q == lcf_pkg::LCF_CMD && !start_ev
            && !stop_ev;
    endsequence

    a_wr_on_match: assert property (
        s_data_byte |=> (wr_q == $past(sub_match)) && wr_ptr_q == $past(ptr_q))
        else $error("write gating wrong");
    a_skip_advance: assert property (
        s_data_byte ##0 !sub_match |=> !wr_q && ptr_q != $past(ptr_q))
        else $error("skipped byte did not advance");
    a_sub_overflow: assert property (
        s_data_byte ##0 ptr_sum > {1'b0, lcf_pkg::PTR_LAST}
        |=> sub_q == $past(sub_q) + 3'h1)
        else $error("subaddress not bumped");
    a_dev_select: assert property (
        s_cmd_end ##0 shift_q[6:3] == 4'hC |=> sub_q == $past(shift_q[2:0]))
        else $error("device select not loaded");
    a_start_fresh: assert property (
        start_ev |=> phase_q == lcf_pkg::LCF_ADDR && !sda_oe && bit_q == 4'h0)
        else $error("start did not restart");
    a_ack_hold: assert property (
        ack_q && scl_s && !start_ev && !stop_ev |=> ack_q)
        else $error("ack released while clock high");
    a_ack_only: assert property (
        sda_oe |-> in_ack_q && phase_q != lcf_pkg::LCF_IGNORE)
        else $error("drive outside ack slot");
    a_addr_ack: assert property (
        in_ack_q && ack_q && phase_q == lcf_pkg::LCF_ADDR |->
        shift_q == {lcf_pkg::SLAVE_ADDR_BASE[6:1], sa_s, 1'b0})
        else $error("wrong address acknowledged");
    a_blink_off: assert property (
        rate_q == 2'h0 |=> !bph_q && bcnt_q == 12'h000)
        else $error("blink runs while off");
    a_data_phase: assert property (
        s_cmd_end ##0 !shift_q[7] |=> phase_q == lcf_pkg::LCF_DATA)
        else $error("data phase not entered");
endmodule : lcf_front

// >>> verif/lcf_host.sv
`timescale 1ns/10ps
module lcf_host (
    input wire logic ref_clk,
    input wire logic sda_oe,
    output logic scl,
    output logic sda
);
    logic drv;
    // Open drain with pull-up: a released line reads high
    assign sda = drv & ~sda_oe;
    initial begin
        drv = 1'b1;
        scl = 1'b1;
    end
    task automatic hold(input int n);
        repeat (n) @(posedge ref_clk);
    endtask : hold
    task automatic start();
        drv <= 1'b1;
        hold(4);
        scl <= 1'b1;
        hold(8);
        drv <= 1'b0;
        hold(8);
        scl <= 1'b0;
        hold(4);
    endtask : start
    task automatic stop();
        drv <= 1'b0;
        hold(4);
        scl <= 1'b1;
        hold(8);
        drv <= 1'b1;
        hold(8);
    endtask : stop
    // data moves only while clock low
    task automatic clk_bit(input logic b, output logic s0, output logic s1);
        drv <= b;
        hold(4);
        scl <= 1'b1;
        @(negedge ref_clk);
        s0 = sda;
        repeat (7) @(negedge ref_clk);
        s1 = sda;
        @(posedge ref_clk);
        scl <= 1'b0;
        hold(4);
    endtask : clk_bit
    // Fewer than eight bits leaves a partial byte with no ack clock
    task automatic send(input logic [7:0] b, input int nbits,
                        output logic ack);
        logic a0;
        logic a1;
        ack = 1'b0;
        for (int i = 7; i > 7 - nbits; i--) clk_bit(b[i], a0, a1);
        if (nbits == 8) begin
            clk_bit(1'b1, a0, a1);
            // low at start and end of the high phase
            ack = (a0 === 1'b0) && (a1 === 1'b0);
        end
    endtask : send
endmodule : lcf_host

// >>> verif/lcf_front_test.sv
`timescale 1ns/10ps
module lcf_front_test;
    localparam int D1 = 8;
    localparam int D2 = 16;
    localparam int D3 = 32;
    logic ref_clk, rst_n, sa, scl, sda, sda_oe, sda_out;
    logic wr_en, wr_bank, en, bias, m1, m0, ib, ob, alt, r1, r0, don, obe;
    logic [2:0] hw;
    logic [2:0] sub;
    logic [5:0] wr_ptr;
    logic [5:0] dptr;
    logic [7:0] wr_byte;
    logic [31:0] seed;
    logic [14:0] wq[$];
    int fail_count, total_checks, cyc;
    int m_en, m_bias, m_mode, m_ptr, m_sub, m_ib, m_ob, m_alt, m_rate;
    int dv[4] = '{0, D1, D2, D3};

    lcf_host host (.ref_clk(ref_clk), .sda_oe(sda_oe), .scl(scl), .sda(sda));
    lcf_front #(.BLINK_DIV1(D1), .BLINK_DIV2(D2), .BLINK_DIV3(D3)) dut (
        .ref_clk(ref_clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe(sda_oe), .hw_subaddr_bit0(hw[0]),
        .hw_subaddr_bit1(hw[1]), .hw_subaddr_bit2(hw[2]),
        .slave_addr_lsb_pin(sa), .ram_wr_en(wr_en), .ram_wr_ptr(wr_ptr),
        .ram_wr_byte(wr_byte), .ram_wr_bank(wr_bank), .display_enable(en),
        .bias_sel(bias), .drive_mode_hi(m1), .drive_mode_lo(m0),
        .data_ptr(dptr), .subaddr_cnt(sub), .in_bank(ib), .out_bank(ob),
        .blink_alt(alt), .blink_rate_hi(r1), .blink_rate_lo(r0),
        .display_on(don), .out_bank_eff(obe)
    );

    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : close_out

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask : check

    // Hang guard, well above the expected run length
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 60000) begin
            fail_count++;
            close_out();
        end
    end

    // Every store must match the next one the model predicted
    always @(negedge ref_clk) begin
        if (wr_en === 1'b1) begin
            if (wq.size() == 0) check(1, 0);
            else check({wr_bank, wr_ptr, wr_byte}, wq.pop_front());
        end
    end

    task automatic stat_chk(input string name);
        logic [17:0] e;
        e = {m_en[0], m_bias[0], m_mode[1:0], m_ptr[5:0], m_sub[2:0],
             m_ib[0], m_ob[0], m_alt[0], m_rate[1:0]};
        @(negedge ref_clk);
        check({en, bias, m1, m0, dptr, sub, ib, ob, alt, r1, r0}, e);
        check(sda_oe, 0);
        check(sda_out, 0);
        @(posedge ref_clk);
        $display("test %0s done", name);
    endtask : stat_chk

    task automatic addr(input logic b0, input logic rw, input logic exp);
        logic a;
        host.start();
        host.send({6'h1C, b0, rw}, 8, a);
        check(a, exp);
    endtask : addr

    task automatic cmd(input logic [7:0] b);
        logic a;
        host.send(b, 8, a);
        check(a, 1);
        // command decode, bit 4 of mode-set ignored
        if (!b[6]) begin
            m_ptr = b[5:0];
        end else if (!b[5]) begin
            m_en = b[3];
            m_bias = b[2];
            m_mode = b[1:0];
        end else if (b[4:3] == 2'b00) begin
            m_sub = b[2:0];
        end else if (b[4:3] == 2'b11) begin
            m_ib = b[1];
            m_ob = b[0];
        end else if (b[4:3] == 2'b10) begin
            m_alt = b[2];
            m_rate = b[1:0];
        end
    endtask : cmd

    task automatic data(input logic [7:0] b);
        logic a;
        int s;
        s = m_mode == 1 ? 8 : m_mode == 2 ? 4 : m_mode == 3 ? 3 : 2;
        if (m_sub == hw) wq.push_back({m_ib[0], m_ptr[5:0], b});
        host.send(b, 8, a);
        check(a, m_sub == hw);
        m_ptr += s;
        if (m_ptr > 39) begin
            m_ptr -= 40;
            m_sub = (m_sub + 1) % 8;
        end
    endtask : data

    task automatic rise(input logic pick, output int n);
        logic p;
        logic c;
        n = 0;
        c = pick ? obe : don;
        do begin
            p = c;
            @(negedge ref_clk);
            c = pick ? obe : don;
            n++;
        end while (!(c && !p) && n < 200);
    endtask : rise

    initial begin
        logic a;
        logic [31:0] r;
        logic [7:0] b;
        int n;
        seed = 32'h8f3c;
        {fail_count, total_checks, cyc} = '0;
        {m_en, m_bias, m_mode, m_ptr, m_sub} = '0;
        {m_ib, m_ob, m_alt, m_rate} = '0;
        rst_n = 1'b0;
        sa = 1'b0;
        hw = 3'h0;
        repeat (12) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge ref_clk);
        stat_chk("reset");
        for (int i = 0; i < 2; i++) begin
            sa <= i[0];
            addr(!i[0], 1'b0, 1'b0);
            host.send(8'hC8, 8, a);
            check(a, 0);
            addr(i[0], 1'b1, 1'b0);
            host.send(8'hC8, 8, a);
            check(a, 0);
            host.stop();
            stat_chk("address");
        end
        for (int md = 0; md < 4; md++) begin
            r = rnd();
            hw <= 3'(r % 3);
            addr(sa, 1'b0, 1'b1);
            cmd({3'b110, r[4], 1'b1, r[5], 2'(md)});
            cmd({2'b10, 6'(r[15:8] % 40)});
            cmd(8'h60);
            for (int k = 0; k < 14; k++) data(8'(rnd()));
            host.stop();
            stat_chk("data");
        end
        addr(sa, 1'b0, 1'b1);
        for (int k = 0; k < 10; k++) begin
            r = rnd();
            case (k % 5)
                0: b = {3'b110, r[4:0]};
                1: b = {2'b10, 6'(r % 40)};
                2: b = {5'b11100, r[2:0]};
                3: b = {6'b111110, r[1:0]};
                default: b = {5'b11110, r[2:0]};
            endcase
            cmd(b);
        end
        cmd({5'b01101, r[2:0]});
        host.stop();
        stat_chk("commands");
        addr(sa, 1'b0, 1'b1);
        host.send(8'hC3, 5, a);
        addr(sa, 1'b0, 1'b1);
        cmd(8'h05);
        host.stop();
        stat_chk("restart");
        for (int rt = 1; rt < 4; rt++) begin
            for (int al = 0; al < 2; al++) begin
                addr(sa, 1'b0, 1'b1);
                cmd(8'hC9);
                cmd({5'b01110, al[0], 2'(rt)});
                host.stop();
                rise(al[0], n);
                rise(al[0], n);
                check(n, dv[rt]);
                if (al) check(don, 1);
            end
        end
        // Triplex has no spare bank, so alternate blink must not swap
        addr(sa, 1'b0, 1'b1);
        cmd(8'hCB);
        cmd(8'h75);
        host.stop();
        rise(1'b1, n);
        check(n, 200);
        check(obe, m_ob[0]);
        addr(sa, 1'b0, 1'b1);
        cmd(8'hC9);
        cmd(8'h70);
        host.stop();
        repeat (40) @(negedge ref_clk);
        check(don, 1);
        addr(sa, 1'b0, 1'b1);
        cmd(8'h41);
        host.stop();
        stat_chk("blink");
        check(don, 0);
        check(wq.size(), 0);
        close_out();
    end
endmodule : lcf_front_test
